// >>> watchdog_timer_with_control_bench.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module watchdog_timer_with_control_bench
    import wdtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int B = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_exec = 1'b0;
    logic watchdog_clear_instruction = 1'b0;
    logic primary_osc_fail = 1'b0;
    logic secondary_timer_osc_fail = 1'b0;
    logic low_voltage_detect = 1'b0;
    logic sleep_mode = 1'b0;
    logic internal_rc_osc;
    logic regulator_lowpower;
    logic watchdog_reset;
    logic watchdog_wake;
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int n_checks = 0;
    int n;
    int n_rst = 0;
    int m;

    // A short base count keeps the postscale taps run here (0 to 6) within a few hundred cycles.
    wdtc_top #(.BASE_CYCLES(B)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
        .watchdog_clear_instruction(watchdog_clear_instruction),
        .primary_osc_fail(primary_osc_fail), .secondary_timer_osc_fail(secondary_timer_osc_fail),
        .low_voltage_detect(low_voltage_detect), .sleep_mode(sleep_mode),
        .internal_rc_osc(internal_rc_osc), .regulator_lowpower(regulator_lowpower),
        .watchdog_reset(watchdog_reset), .watchdog_wake(watchdog_wake));

    // Clock and a count of every reset pulse, used to prove that clears hold it off.
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (watchdog_reset === 1'b1) n_rst++;

    task automatic report_and_stop;
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer; the answer is taken at the edge where pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            failures++;
            report_and_stop();
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // One-cycle pulse on a clear or detect input chosen by k.
    task automatic pulse_in(input int k);
        @(posedge pclk);
        case (k)
            0: sleep_exec <= 1'b1;
            1: watchdog_clear_instruction <= 1'b1;
            2: primary_osc_fail <= 1'b1;
            3: secondary_timer_osc_fail <= 1'b1;
            default: low_voltage_detect <= 1'b1;
        endcase
        @(posedge pclk);
        {sleep_exec, watchdog_clear_instruction} <= 2'b00;
        {primary_osc_fail, secondary_timer_osc_fail, low_voltage_detect} <= 3'b000;
    endtask

    // Counts settled cycles until a timeout pulse shows; a hang counts as a mismatch.
    task automatic wait_to(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (n < lim && watchdog_reset !== 1'b1 && watchdog_wake !== 1'b1);
        if (n == lim) begin
            failures++;
            report_and_stop();
        end
    endtask

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    // Main sequence: registers, postscale taps, clear sources, wake, regulator bit.
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CTRL_OFS, 32'h0);
        rdchk(CAUSE_OFS, 32'h0);
        rdchk(CFG_OFS, 32'hf);
        apb(1'b1, CTRL_OFS, 32'hff);
        #1 `CHK(internal_rc_osc, 1'b1)
        rdchk(CTRL_OFS, 32'h81);
        apb(1'b1, CTRL_OFS, 32'h0);
        #1 `CHK(internal_rc_osc, 1'b0)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        // The pulse shows one cycle after the last base cycle of the selected tap.
        for (int s = 0; s < 7; s++) begin
            apb(1'b1, CFG_OFS, 32'(s));
            apb(1'b1, CTRL_OFS, 32'h1);
            wait_to(4000);
            `CHK(n, 1 + (1 << s) * B)
            @(posedge pclk);
            #1 `CHK(watchdog_reset, 1'b0)
            apb(1'b1, CTRL_OFS, 32'h0);
        end
        rdchk(CAUSE_OFS, 32'h1);
        apb(1'b1, CAUSE_OFS, 32'h1);
        rdchk(CAUSE_OFS, 32'h0);
        // Clears every two cycles must keep a four-cycle timeout from ever firing.
        apb(1'b1, CFG_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        m = n_rst;
        for (int k = 0; k < 4; k++) repeat (8) pulse_in(k);
        `CHK(n_rst, m)
        wait_to(20);
        `CHK(watchdog_reset, 1'b1)
        @(posedge pclk);
        sleep_mode <= 1'b1;
        wait_to(40);
        `CHK({watchdog_wake, watchdog_reset}, 2'b10)
        rdchk(CAUSE_OFS, 32'h3);
        // Configuration enable runs the watchdog although the software bit is off.
        apb(1'b1, CFG_OFS, 32'h10);
        apb(1'b1, CTRL_OFS, 32'h0);
        #1 `CHK(internal_rc_osc, 1'b1)
        wait_to(40);
        `CHK(watchdog_wake, 1'b1)
        apb(1'b1, CFG_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h80);
        #1 `CHK(regulator_lowpower, 1'b1)
        pulse_in(4);
        rdchk(CTRL_OFS, 32'h0);
        `CHK(regulator_lowpower, 1'b0)
        report_and_stop();
    end
endmodule

// >>> wdtc_pkg.sv
package wdtc_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CAUSE_OFS = 12'h004;
    localparam logic [11:0] CFG_OFS = 12'h008;
    localparam int ADDR_W = 12;

    // Control register fields and reset values.
    localparam int SWEN_BIT = 0;
    localparam int LOWPWR_BIT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Reset cause fields, cleared by writing a one.
    localparam int TOUT_BIT = 0;
    localparam int WAKE_BIT = 1;

    // Configuration fields: postscale select and configuration enable.
    localparam int PS_LSB = 0;
    localparam int PS_W = 4;
    localparam int CFGEN_BIT = 4;
    localparam logic [3:0] PS_RST = 4'hf;
    localparam logic CFGEN_RST = 1'b0;

    // Timing: base period and the longest selectable period.
    localparam int CLK_MHZ = 100;
    localparam int BASE_MS = 4;
    localparam int BASE_CYC = BASE_MS * 1000 * CLK_MHZ;
    localparam int MAX_TIMEOUT_MS = 131072;
    localparam int BASE_W = 19;
    localparam int PSC_W = 16;

    // Watchdog sequencer states, Gray coded along off, count, fire.
    typedef enum logic [1:0] {
        WDTC_OFF = 2'b00,
        WDTC_COUNT = 2'b01,
        WDTC_FIRE = 2'b11
    } wdtc_state_e;
endpackage

// >>> wdtc_top.sv
module wdtc_top
    import wdtc_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic primary_osc_fail,
    input wire logic secondary_timer_osc_fail,
    input wire logic low_voltage_detect,
    input wire logic sleep_mode,
    output logic internal_rc_osc,
    output logic regulator_lowpower,
    output logic watchdog_reset,
    output logic watchdog_wake
);
    logic software_watchdog_enable;
    logic regulator_sleep_lowpower;
    logic [PS_W-1:0] postscale_select;
    logic config_watchdog_enable;
    logic tout_flag;
    logic wake_flag;
    logic [BASE_W-1:0] base_cnt;
    logic [PSC_W-1:0] psc_cnt;
    wdtc_state_e state;
    wdtc_state_e next_state;

    // Bus decode. Reads are captured in the setup cycle so the access phase
    // can always answer at once with data straight from a flip-flop.
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_cause = (paddr == CAUSE_OFS);
    wire hit_cfg = (paddr == CFG_OFS);
    wire mapped = hit_ctrl || hit_cause || hit_cfg;
    wire wr_ctrl = access_ph && pwrite && hit_ctrl;
    wire wr_cause = access_ph && pwrite && hit_cause;
    wire wr_cfg = access_ph && pwrite && hit_cfg;
    assign pready = access_ph;
    assign pslverr = access_ph && !mapped;

    // Read views; unimplemented bits stay zero.
    wire [31:0] ctrl_view = {24'h000000, regulator_sleep_lowpower, 6'h00,
                             software_watchdog_enable};
    wire [31:0] cause_view = {30'h00000000, wake_flag, tout_flag};
    wire [31:0] cfg_view = {27'h0000000, config_watchdog_enable, postscale_select};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                         hit_cause ? cause_view :
                         hit_cfg ? cfg_view : 32'h00000000;

    // Enable and clear terms.
    wire wdt_on = config_watchdog_enable || software_watchdog_enable;
    wire clr_instr = sleep_exec || watchdog_clear_instruction;
    wire clk_fail = primary_osc_fail || secondary_timer_osc_fail;
    wire clear_any = clr_instr || clk_fail || !wdt_on;
    assign internal_rc_osc = wdt_on;

    // Base period: one pass of the counter is BASE_CYCLES pclk cycles, 4 ms at the 100 MHz default.
    wire base_done = (base_cnt == BASE_W'(BASE_CYCLES - 1));

    // Tap mask: code n waits for 2**n base periods, so 0000 gives 1:1 and
    // 1111 gives 1:32768, 131.072 s at the 4 ms base.
    wire [PSC_W-1:0] tap_mask = PSC_W'((17'h00001 << postscale_select) - 17'h00001);
    wire tap_hit = base_done && ((psc_cnt & tap_mask) == tap_mask);
    wire expire = (state == WDTC_COUNT) && tap_hit && !clear_any;

    // One timeout pulse, routed by the power mode.
    assign watchdog_reset = (state == WDTC_FIRE) && !sleep_mode;
    assign watchdog_wake = (state == WDTC_FIRE) && sleep_mode;
    assign regulator_lowpower = regulator_sleep_lowpower && sleep_mode;

    // Sequencer next state. The fire state lasts one cycle, which makes the
    // timeout a single pulse however long the clear inputs stay low, and the
    // count restarts from zero behind it.
    always_comb begin
        next_state = state;
        case (state)
            WDTC_OFF: begin
                if (wdt_on) begin
                    next_state = WDTC_COUNT;
                end
            end
            WDTC_COUNT: begin
                if (!wdt_on) begin
                    next_state = WDTC_OFF;
                end else if (expire) begin
                    next_state = WDTC_FIRE;
                end
            end
            WDTC_FIRE: begin
                next_state = wdt_on ? WDTC_COUNT : WDTC_OFF;
            end
            default: begin
                next_state = WDTC_OFF;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= WDTC_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Base counter and postscaler; any clear term restarts both from zero.
    // Holding them at zero outside the count state means a stale partial count
    // can never shorten the first period after an enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= '0;
            psc_cnt <= '0;
        end else if (clear_any || state != WDTC_COUNT) begin
            base_cnt <= '0;
            psc_cnt <= '0;
        end else if (base_done) begin
            base_cnt <= '0;
            psc_cnt <= tap_hit ? '0 : psc_cnt + 16'h0001;
        end else begin
            base_cnt <= base_cnt + 19'h00001;
        end
    end

    // Control register. A low-voltage detect beats a software set of the
    // regulator bit in the same cycle, since the supply is already failing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            software_watchdog_enable <= CTRL_RST[SWEN_BIT];
            regulator_sleep_lowpower <= CTRL_RST[LOWPWR_BIT];
        end else begin
            if (wr_ctrl) begin
                software_watchdog_enable <= pwdata[SWEN_BIT];
            end
            if (low_voltage_detect) begin
                regulator_sleep_lowpower <= 1'b0;
            end else if (wr_ctrl) begin
                regulator_sleep_lowpower <= pwdata[LOWPWR_BIT];
            end
        end
    end

    // Configuration register with the postscale select and configuration enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            postscale_select <= PS_RST;
            config_watchdog_enable <= CFGEN_RST;
        end else if (wr_cfg) begin
            postscale_select <= pwdata[PS_LSB +: PS_W];
            config_watchdog_enable <= pwdata[CFGEN_BIT];
        end
    end

    // Reset cause flags: write one to clear, and a new event wins the cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_flag <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            if (watchdog_reset) begin
                tout_flag <= 1'b1;
            end else if (wr_cause && pwdata[TOUT_BIT]) begin
                tout_flag <= 1'b0;
            end
            if (watchdog_wake) begin
                wake_flag <= 1'b1;
            end else if (wr_cause && pwdata[WAKE_BIT]) begin
                wake_flag <= 1'b0;
            end
        end
    end

    // Read data is held from the setup cycle through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
        end
    end

    // The checks below run on the bus clock and stand down while reset is held,
    // because every register is still forced to its reset value then and the
    // sampled history of the first edge after release is not meaningful.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_write;
        psel && penable && pwrite && paddr == CTRL_OFS;
    endsequence

    sequence s_ctrl_read;
        psel && !penable && !pwrite && paddr == CTRL_OFS ##1 psel && penable;
    endsequence

    osc_enable_a: assert property (wdt_on |-> internal_rc_osc)
        else $error("RC oscillator off while watchdog enabled");
    base_wrap_a: assert property (state == WDTC_COUNT && base_done && !clear_any
        |=> base_cnt == 0)
        else $error("base counter did not wrap at the base period");
    tap_mux_a: assert property (expire |-> (psc_cnt & tap_mask) == tap_mask
        && base_cnt == BASE_W'(BASE_CYCLES - 1))
        else $error("timeout not at the selected postscaler tap");
    div_one_a: assert property (postscale_select == 4'h0 && state == WDTC_COUNT
        && base_done && !clear_any |=> state == WDTC_FIRE)
        else $error("divide by one did not expire on the first base period");
    clear_cnt_a: assert property (clr_instr && state == WDTC_COUNT
        |=> base_cnt == 0 && psc_cnt == 0)
        else $error("clear instruction did not clear the counts");
    fail_clear_a: assert property (clk_fail |=> base_cnt == 0 && psc_cnt == 0
        && !watchdog_reset && !watchdog_wake)
        else $error("clock failure did not clear the counts");
    swen_write_a: assert property (s_ctrl_write ##0 !low_voltage_detect
        |=> software_watchdog_enable == $past(pwdata[SWEN_BIT])
        && regulator_sleep_lowpower == $past(pwdata[LOWPWR_BIT]))
        else $error("control write not stored");
    cfg_override_a: assert property (config_watchdog_enable
        && !software_watchdog_enable |-> internal_rc_osc)
        else $error("configuration enable did not keep watchdog on");
    lvd_clear_a: assert property (low_voltage_detect |=> !regulator_sleep_lowpower
        && !regulator_lowpower)
        else $error("low-voltage detect did not clear regulator bit");
    rsvd_zero_a: assert property (s_ctrl_read |-> prdata[6:1] == 6'h00)
        else $error("reserved control bits read nonzero");
    fire_route_a: assert property (expire |=> watchdog_reset != watchdog_wake
        ##1 !watchdog_reset && !watchdog_wake)
        else $error("timeout pulse missing or not one cycle");

    // A timeout pulse of each kind, used to check the flag that it leaves behind.
    sequence s_run_timeout;
        watchdog_reset && !watchdog_wake;
    endsequence

    sequence s_sleep_timeout;
        watchdog_wake && !watchdog_reset;
    endsequence

    // The reset cause flags record each pulse, and software can only clear a
    // flag in a cycle with no new event of its kind.
    tout_flag_a: assert property (s_run_timeout |=> tout_flag)
        else $error("run timeout did not set its cause flag");
    wake_flag_a: assert property (s_sleep_timeout |=> wake_flag)
        else $error("sleep timeout did not set its cause flag");
    cause_clear_a: assert property (wr_cause && pwdata[TOUT_BIT] && !watchdog_reset
        |=> !tout_flag)
        else $error("timeout cause flag not cleared by a one");
    pulse_excl_a: assert property (!(watchdog_reset && watchdog_wake))
        else $error("reset and wake pulses raised together");

    // Disabling the watchdog parks the sequencer with both counts at zero, so a
    // later enable starts a full period; a set configuration enable keeps it running.
    sw_off_a: assert property (!config_watchdog_enable && !software_watchdog_enable
        |=> state == WDTC_OFF && base_cnt == 0 && psc_cnt == 0)
        else $error("watchdog kept counting while disabled");
    osc_off_a: assert property (!config_watchdog_enable && !software_watchdog_enable
        |-> !internal_rc_osc)
        else $error("RC oscillator left on while watchdog disabled");
    cfg_lock_a: assert property (config_watchdog_enable |=> state != WDTC_OFF)
        else $error("configuration enable did not keep the sequencer running");

    // Count steps: the base counter climbs by one, the postscaler by one per base period.
    base_step_a: assert property (state == WDTC_COUNT && !clear_any && !base_done
        |=> base_cnt == $past(base_cnt) + 19'h00001)
        else $error("base counter did not advance by one");
    psc_step_a: assert property (state == WDTC_COUNT && !clear_any && base_done && !tap_hit
        |=> psc_cnt == $past(psc_cnt) + 16'h0001)
        else $error("postscaler did not advance at the base period");
    cfg_write_a: assert property (wr_cfg
        |=> postscale_select == $past(pwdata[PS_LSB +: PS_W]))
        else $error("postscale select write not stored");

    // The regulator bit only moves on a write or a low-voltage detect, and its
    // output is gated by Sleep.
    reg_hold_a: assert property (!low_voltage_detect && !wr_ctrl
        |=> $stable(regulator_sleep_lowpower))
        else $error("regulator bit changed without a cause");
    reg_route_a: assert property (regulator_lowpower |-> sleep_mode
        && regulator_sleep_lowpower)
        else $error("regulator low power outside Sleep");
endmodule
